// ===== rtl/t16_timer.sv
// 16-bit timer/counter: byte registers, shared high byte, compare, capture, flags
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`include "t16_cfg.svh"
module t16_timer import t16_pkg::*; (
    input wire logic mclk,
    input wire logic rst,
    input wire t16_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic ext_clk_pin,
    input wire logic capture_input_pin,
    input wire logic analog_cmp_out,
    input wire logic global_irq_enable,
    input wire t16_flags_t vector_ack,
    output logic [1:0] compare_output_pin,
    output logic irq
);

    // ***********************************************************************
    // Decoding functions
    // ***********************************************************************
    function automatic t16_kind_t kind_of(input logic [3:0] m);
        case (m)
            T16_M_NORMAL, T16_M_RSVD: kind_of = T16_K_NORMAL;
            T16_M_CTC_A, T16_M_CTC_I: kind_of = T16_K_CTC;
            T16_M_FP8, T16_M_FP9, T16_M_FP10, T16_M_FP_I, T16_M_FP_A: kind_of = T16_K_FAST;
            default: kind_of = T16_K_PHASE;
        endcase
    endfunction

    function automatic logic capt_is_top(input logic [3:0] m);
        capt_is_top = (m == T16_M_PFC_I) || (m == T16_M_PC_I) || (m == T16_M_CTC_I) ||
                      (m == T16_M_FP_I);
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                           input logic [15:0] cp);
        case (m)
            T16_M_PC8, T16_M_FP8: top_of = `T16_TOP_8BIT;
            T16_M_PC9, T16_M_FP9: top_of = `T16_TOP_9BIT;
            T16_M_PC10, T16_M_FP10: top_of = `T16_TOP_10BIT;
            T16_M_CTC_A, T16_M_PFC_A, T16_M_PC_A, T16_M_FP_A: top_of = ca;
            T16_M_PFC_I, T16_M_PC_I, T16_M_CTC_I, T16_M_FP_I: top_of = cp;
            default: top_of = `T16_MAX;
        endcase
    endfunction

    function automatic logic is_addr(input t16_bus_req_t b, input logic [`T16_AW-1:0] a);
        is_addr = b.addr == a;
    endfunction

    // ***********************************************************************
    // Declarations
    // ***********************************************************************
    logic [7:0] temp;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    t16_dir_t dir;
    t16_dir_t next_dir;
    logic [15:0] cmp_buf [2];
    logic [15:0] cmp_act [2];
    logic [15:0] capture;
    logic [3:0] mask;
    t16_flags_t flags;
    t16_flags_t set_ev;
    t16_flags_t clr_ev;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic capt_src;
    logic [3:0] wgm;
    t16_kind_t kind;
    logic pwm;
    logic [15:0] top;
    logic [`T16_PRE_W-1:0] pre;
    logic ext_prev;
    logic tick;
    logic block;
    logic [1:0] hit;
    logic [1:0] force_wr;
    logic upd;
    logic wrap;
    logic ovf_ev;
    logic [`T16_NOISE_SAMPLES-1:0] samp;
    logic filt;
    logic filt_prev;
    logic cap_ev;
    logic cnt_wr;
    logic [7:0] next_rd;

    assign wgm = {ctrl_b[`T16_WGM_HI_MSB:`T16_WGM_HI_LSB], ctrl_a[`T16_WGM_LO_MSB:0]};
    assign kind = kind_of(wgm);
    assign pwm = (kind == T16_K_FAST) || (kind == T16_K_PHASE);
    assign top = top_of(wgm, cmp_act[0], capture);
    assign cnt_wr = bus_req.wr && is_addr(bus_req, `T16_ADDR_COUNT_L);

    // ***********************************************************************
    // Control registers
    // ***********************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_a <= `T16_CTRL_RESET;
            ctrl_b <= `T16_CTRL_RESET;
            capt_src <= 1'b0;
            mask <= `T16_IRQ_RESET;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `T16_ADDR_CTRL_A: ctrl_a <= {2'b00, bus_req.wdata[5:0]};
                `T16_ADDR_CTRL_B: ctrl_b <= bus_req.wdata;
                `T16_ADDR_CTRL_C: capt_src <= bus_req.wdata[`T16_CAPSRC_BIT];
                `T16_ADDR_MASK: mask <= bus_req.wdata[`T16_IRQ_MSB:`T16_IRQ_LSB];
                default: ;
            endcase
        end
    end

    // ***********************************************************************
    // Shared high-byte buffer
    // ***********************************************************************
    // one buffer for every word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            temp <= 8'h00;
        end else if (bus_req.wr && bus_req.addr[0]) begin
            temp <= bus_req.wdata;
        end else if (bus_req.rd && is_addr(bus_req, `T16_ADDR_COUNT_L)) begin
            temp <= cnt[15:8];
        end else if (bus_req.rd && is_addr(bus_req, `T16_ADDR_CAPT_L)) begin
            temp <= capture[15:8];
        end
    end

    // ***********************************************************************
    // Timer clock enable
    // ***********************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pre <= '0;
            ext_prev <= 1'b0;
        end else begin
            pre <= pre + `T16_PRE_W'(1);
            ext_prev <= ext_clk_pin;
        end
    end

    always_comb begin
        case (t16_cs_t'(ctrl_b[`T16_CS_MSB:0]))
            T16_CS_DIV1: tick = 1'b1;
            T16_CS_DIV8: tick = &pre[`T16_DIV8_LOG-1:0];
            T16_CS_DIV64: tick = &pre[`T16_DIV64_LOG-1:0];
            T16_CS_DIV256: tick = &pre[`T16_DIV256_LOG-1:0];
            T16_CS_DIV1024: tick = &pre[`T16_DIV1024_LOG-1:0];
            T16_CS_EXT_FALL: tick = ext_prev && !ext_clk_pin;
            T16_CS_EXT_RISE: tick = !ext_prev && ext_clk_pin;
            default: tick = 1'b0;
        endcase
    end

    // ***********************************************************************
    // Counter sequence
    // ***********************************************************************
    // mode selects sequence and top
    always_comb begin
        next_cnt = cnt + 16'h0001;
        next_dir = dir;
        case (kind)
            T16_K_NORMAL: next_cnt = cnt + 16'h0001;
            T16_K_CTC: next_cnt = (cnt == top) ? 16'h0000 : cnt + 16'h0001;
            T16_K_FAST: next_cnt = (cnt >= top) ? 16'h0000 : cnt + 16'h0001;
            T16_K_PHASE: begin
                if (dir == T16_UP) begin
                    if (cnt >= top) begin
                        next_dir = T16_DOWN;
                        next_cnt = cnt - 16'h0001;
                    end
                end else if (cnt == 16'h0000) begin
                    next_dir = T16_UP;
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            default: next_cnt = cnt + 16'h0001;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= `T16_WORD_RESET;
            dir <= T16_UP;
        end else if (cnt_wr) begin
            cnt <= {temp, bus_req.wdata};
        end else if (tick) begin
            cnt <= next_cnt;
            dir <= next_dir;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            block <= 1'b0;
        end else if (cnt_wr) begin
            block <= 1'b1;
        end else if (tick) begin
            block <= 1'b0;
        end
    end

    assign wrap = tick && (kind == T16_K_FAST) && (cnt >= top);
    always_comb begin
        case (kind)
            T16_K_NORMAL, T16_K_CTC: ovf_ev = tick && (cnt == `T16_MAX);
            T16_K_FAST: ovf_ev = wrap;
            T16_K_PHASE: ovf_ev = tick && (dir == T16_DOWN) && (cnt == 16'h0000);
            default: ovf_ev = 1'b0;
        endcase
    end

    // Update point for buffered compare words in waveform modes
    assign upd = tick && (((wgm == T16_M_PFC_I) || (wgm == T16_M_PFC_A)) ?
                 ((dir == T16_DOWN) && (cnt == 16'h0000)) : (cnt >= top));

    // ***********************************************************************
    // Compare channels
    // ***********************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        localparam logic [`T16_AW-1:0] LO = (i == 0) ? `T16_ADDR_CMPA_L : `T16_ADDR_CMPB_L;

        assign force_wr[i] = bus_req.wr && is_addr(bus_req, `T16_ADDR_CTRL_A) &&
                             bus_req.wdata[`T16_FORCE_A_BIT-i];
        assign hit[i] = tick && (cnt == cmp_act[i]) && !block;

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cmp_buf[i] <= `T16_WORD_RESET;
            end else if (bus_req.wr && is_addr(bus_req, LO)) begin
                cmp_buf[i] <= {temp, bus_req.wdata};
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cmp_act[i] <= `T16_WORD_RESET;
            end else if (!pwm || upd) begin
                cmp_act[i] <= cmp_buf[i];
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                compare_output_pin[i] <= 1'b0;
            end else if (force_wr[i] && !pwm) begin
                compare_output_pin[i] <= !compare_output_pin[i];
            end else if (hit[i]) begin
                case (kind)
                    T16_K_FAST: compare_output_pin[i] <= 1'b0;
                    T16_K_PHASE: compare_output_pin[i] <= (dir == T16_DOWN);
                    default: compare_output_pin[i] <= !compare_output_pin[i];
                endcase
            end else if (wrap) begin
                compare_output_pin[i] <= 1'b1;
            end
        end
    end

    // ***********************************************************************
    // Input capture
    // ***********************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            samp <= '0;
            filt <= 1'b0;
            filt_prev <= 1'b0;
        end else begin
            samp <= {samp[`T16_NOISE_SAMPLES-2:0],
                     capt_src ? analog_cmp_out : capture_input_pin};
            if (!ctrl_b[`T16_NOISE_BIT]) begin
                filt <= samp[0];
            end else if (&samp) begin
                filt <= 1'b1;
            end else if (~|samp) begin
                filt <= 1'b0;
            end
            filt_prev <= filt;
        end
    end

    // input disconnected when capture is top
    assign cap_ev = !capt_is_top(wgm) &&
                    (ctrl_b[`T16_EDGE_BIT] ? (filt && !filt_prev) : (!filt && filt_prev));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            capture <= `T16_WORD_RESET;
        end else if (cap_ev) begin
            capture <= cnt;
        end else if (bus_req.wr && is_addr(bus_req, `T16_ADDR_CAPT_L)) begin
            capture <= {temp, bus_req.wdata};
        end
    end

    // ***********************************************************************
    // Flags and interrupt
    // ***********************************************************************
    always_comb begin
        set_ev.capt = cap_ev || (capt_is_top(wgm) && tick && (cnt == top));
        set_ev.cmpa = hit[0];
        set_ev.cmpb = hit[1];
        set_ev.ovf = ovf_ev;
        clr_ev = vector_ack;
        if (bus_req.wr && is_addr(bus_req, `T16_ADDR_FLAGS)) begin
            clr_ev = clr_ev | t16_flags_t'(bus_req.wdata[`T16_IRQ_MSB:`T16_IRQ_LSB]);
        end
    end

    // write one or vector clears; set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags <= `T16_IRQ_RESET;
        end else begin
            flags <= (flags & ~clr_ev) | set_ev;
        end
    end

    assign irq = global_irq_enable && |(mask & flags);

    // ***********************************************************************
    // Read port
    // ***********************************************************************
    always_comb begin
        case (bus_req.addr)
            `T16_ADDR_COUNT_L: next_rd = cnt[7:0];
            `T16_ADDR_CMPA_L: next_rd = cmp_buf[0][7:0];
            `T16_ADDR_CMPA_H: next_rd = cmp_buf[0][15:8];
            `T16_ADDR_CMPB_L: next_rd = cmp_buf[1][7:0];
            `T16_ADDR_CMPB_H: next_rd = cmp_buf[1][15:8];
            `T16_ADDR_CAPT_L: next_rd = capture[7:0];
            `T16_ADDR_COUNT_H, `T16_ADDR_CAPT_H: next_rd = temp;
            `T16_ADDR_MASK: next_rd = {2'b00, mask, 2'b00};
            `T16_ADDR_FLAGS: next_rd = {2'b00, flags, 2'b00};
            `T16_ADDR_CTRL_A: next_rd = ctrl_a;
            `T16_ADDR_CTRL_B: next_rd = ctrl_b;
            `T16_ADDR_CTRL_C: next_rd = {7'h00, capt_src};
            default: next_rd = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= bus_req.rd ? next_rd : 8'h00;
        end
    end

    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_read_cnt_pair;
        bus_req.rd && bus_req.addr == `T16_ADDR_COUNT_L ##1
        bus_req.rd && bus_req.addr == `T16_ADDR_COUNT_H;
    endsequence

    sequence s_write_cmpa_pair;
        bus_req.wr && bus_req.addr == `T16_ADDR_CMPA_H ##1
        bus_req.wr && bus_req.addr == `T16_ADDR_CMPA_L;
    endsequence

    chk_irq_gating: assert property (
        irq == (global_irq_enable && ((mask[3] && flags.capt) || (mask[2] && flags.cmpa) ||
                (mask[1] && flags.cmpb) || (mask[0] && flags.ovf))))
        else $error("interrupt line disagrees with enables and flags");
    chk_flag_w1c: assert property (
        bus_req.wr && bus_req.addr == `T16_ADDR_FLAGS && bus_req.wdata[4] && !hit[0]
        |=> !flags.cmpa)
        else $error("writing one did not clear compare A flag");
    chk_set_wins: assert property (
        hit[0] && (vector_ack.cmpa || (bus_req.wr && bus_req.addr == `T16_ADDR_FLAGS))
        |=> flags.cmpa)
        else $error("compare A event lost to a clear");
    chk_block_after_write: assert property (
        cnt_wr |=> block && !hit[0] && !hit[1])
        else $error("compare match not blocked after counter write");
    chk_cmp_flag_timing: assert property (
        tick && cnt == cmp_act[1] && !block |=> flags.cmpb)
        else $error("compare B flag not set one cycle after match tick");
    chk_force_no_flag: assert property (
        force_wr[0] && !hit[0] && !flags.cmpa |=> !flags.cmpa)
        else $error("force strobe set compare A flag");
    chk_capture_copy: assert property (
        cap_ev |=> capture == $past(cnt) && flags.capt)
        else $error("capture event did not copy the counter");
    chk_capture_off_top: assert property (
        capt_is_top(wgm) |-> !cap_ev)
        else $error("capture taken while capture word is top");
    chk_atomic_read: assert property (
        s_read_cnt_pair |=> rd_data == $past(cnt[15:8], 2))
        else $error("high byte read not paired with low byte read");
    chk_atomic_write: assert property (
        s_write_cmpa_pair |=> cmp_buf[0] == {$past(bus_req.wdata, 2), $past(bus_req.wdata)})
        else $error("compare A word not loaded as one unit");
    chk_ovf_normal: assert property (
        tick && kind == T16_K_NORMAL && cnt == `T16_MAX |=> flags.ovf && cnt == 16'h0000)
        else $error("overflow flag missing at counter wrap");

endmodule

// ===== shared/t16_cfg.svh
// Addresses, field positions, reset values and counts of the 16-bit timer
`ifndef T16_CFG_SVH
`define T16_CFG_SVH

// ***********************************************************************
// Register addresses
// ***********************************************************************
`define T16_AW 4
`define T16_ADDR_COUNT_L 4'h0
`define T16_ADDR_COUNT_H 4'h1
`define T16_ADDR_CMPA_L 4'h2
`define T16_ADDR_CMPA_H 4'h3
`define T16_ADDR_CMPB_L 4'h4
`define T16_ADDR_CMPB_H 4'h5
`define T16_ADDR_CAPT_L 4'h6
`define T16_ADDR_CAPT_H 4'h7
`define T16_ADDR_MASK 4'h8
`define T16_ADDR_FLAGS 4'h9
`define T16_ADDR_CTRL_A 4'hA
`define T16_ADDR_CTRL_B 4'hB
`define T16_ADDR_CTRL_C 4'hC

// ***********************************************************************
// Field positions
// ***********************************************************************
`define T16_IRQ_LSB 2
`define T16_IRQ_MSB 5
`define T16_FORCE_A_BIT 7
`define T16_WGM_LO_MSB 1
`define T16_NOISE_BIT 7
`define T16_EDGE_BIT 6
`define T16_WGM_HI_MSB 4
`define T16_WGM_HI_LSB 3
`define T16_CS_MSB 2
`define T16_CAPSRC_BIT 0

// ***********************************************************************
// Reset values
// ***********************************************************************
`define T16_IRQ_RESET 4'h0
`define T16_CTRL_RESET 8'h00
`define T16_WORD_RESET 16'h0000

// ***********************************************************************
// Counts and fixed top values
// ***********************************************************************
`define T16_PRE_W 10
`define T16_DIV8_LOG 3
`define T16_DIV64_LOG 6
`define T16_DIV256_LOG 8
`define T16_DIV1024_LOG 10
`define T16_NOISE_SAMPLES 4
`define T16_MAX 16'hFFFF
`define T16_TOP_8BIT 16'h00FF
`define T16_TOP_9BIT 16'h01FF
`define T16_TOP_10BIT 16'h03FF

`endif

// ===== shared/t16_pkg.sv
// Types shared by the 16-bit timer design and its bench
`include "t16_cfg.svh"
package t16_pkg;

    // ***********************************************************************
    // Register bus request and flag layout
    // ***********************************************************************
    typedef struct packed {
        logic [`T16_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } t16_bus_req_t;

    typedef struct packed {
        logic capt;
        logic cmpa;
        logic cmpb;
        logic ovf;
    } t16_flags_t;

    // ***********************************************************************
    // Modes, clock selects and states
    // ***********************************************************************
    typedef enum logic [3:0] {
        T16_M_NORMAL = 4'h0, T16_M_PC8 = 4'h1, T16_M_PC9 = 4'h2, T16_M_PC10 = 4'h3,
        T16_M_CTC_A = 4'h4, T16_M_FP8 = 4'h5, T16_M_FP9 = 4'h6, T16_M_FP10 = 4'h7,
        T16_M_PFC_I = 4'h8, T16_M_PFC_A = 4'h9, T16_M_PC_I = 4'hA, T16_M_PC_A = 4'hB,
        T16_M_CTC_I = 4'hC, T16_M_RSVD = 4'hD, T16_M_FP_I = 4'hE, T16_M_FP_A = 4'hF
    } t16_wgm_t;

    typedef enum logic [2:0] {
        T16_CS_STOP = 3'h0, T16_CS_DIV1 = 3'h1, T16_CS_DIV8 = 3'h2, T16_CS_DIV64 = 3'h3,
        T16_CS_DIV256 = 3'h4, T16_CS_DIV1024 = 3'h5, T16_CS_EXT_FALL = 3'h6,
        T16_CS_EXT_RISE = 3'h7
    } t16_cs_t;

    typedef enum logic [3:0] {
        T16_K_NORMAL = 4'b0001,
        T16_K_CTC = 4'b0010,
        T16_K_FAST = 4'b0100,
        T16_K_PHASE = 4'b1000
    } t16_kind_t;

    typedef enum logic [1:0] {
        T16_UP = 2'b01,
        T16_DOWN = 2'b10
    } t16_dir_t;

endpackage

// ===== verification/t16_cpu_model.sv
// CPU core model: byte register bus, global interrupt flag, vector acknowledge
`timescale 1ns/1ns
`include "t16_cfg.svh"
module t16_cpu_model import t16_pkg::*; (
    input wire logic mclk,
    input wire logic [7:0] rd_data,
    output t16_bus_req_t bus_req,
    output logic global_irq_enable,
    output t16_flags_t vector_ack
);
    initial begin
        bus_req = '0;
        global_irq_enable = 1'b0;
        vector_ack = '0;
    end

    // high byte first
    // One write cycle, then one idle cycle
    task automatic bw(input logic [3:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask

    // low byte read first
    // Read data stand only in the cycle after the strobe
    task automatic br(input logic [3:0] a, output logic [7:0] d);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        @(negedge mclk);
        d = rd_data;
        @(posedge mclk);
    endtask

    task automatic ack(input t16_flags_t f);
        vector_ack <= f;
        @(posedge mclk);
        vector_ack <= '0;
        @(posedge mclk);
    endtask

    // Global interrupt flag of the core
    task automatic gie_set(input logic v);
        global_irq_enable <= v;
    endtask

    // high byte then low byte, no gap
    task automatic bw2(input logic [3:0] a, input logic [15:0] d);
        bus_req <= '{addr: a + 4'h1, wdata: d[15:8], wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d[7:0], wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask

    // low byte then high byte, no gap
    task automatic br2(input logic [3:0] a, output logic [15:0] d);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '{addr: a + 4'h1, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge mclk);
        d[7:0] = rd_data;
        @(posedge mclk);
        bus_req <= '0;
        @(negedge mclk);
        d[15:8] = rd_data;
        @(posedge mclk);
    endtask
endmodule

// ===== verification/t16_timer_tb.sv
// Self-checking bench of the 16-bit timer register and flag side
`timescale 1ns/1ns
`include "t16_cfg.svh"
module t16_timer_tb import t16_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cap_pin = 1'b0;
    logic [7:0] rd_data;
    logic [1:0] cmp_pins;
    logic irq;
    logic gie;
    t16_bus_req_t bus_req;
    t16_flags_t vack;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [15:0] v;
    logic [7:0] b;

    t16_timer t16_timer_inst (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .ext_clk_pin(1'b0), .capture_input_pin(cap_pin), .analog_cmp_out(1'b0),
        .global_irq_enable(gie), .vector_ack(vack), .compare_output_pin(cmp_pins),
        .irq(irq));
    t16_cpu_model t16_cpu_model_inst (.mclk(mclk), .rd_data(rd_data), .bus_req(bus_req),
        .global_irq_enable(gie), .vector_ack(vack));

    initial begin
        forever #5 mclk = ~mclk;
    end

    // ***********************************************************************
    // Checking and closing
    // ***********************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic w16(input logic [3:0] a, input logic [15:0] d);
        t16_cpu_model_inst.bw2(a, d);
    endtask

    task automatic r16(input logic [3:0] a, output logic [15:0] d);
        t16_cpu_model_inst.br2(a, d);
    endtask

    task automatic rflags(input logic [7:0] exp);
        t16_cpu_model_inst.br(`T16_ADDR_FLAGS, b);
        chk(b, exp);
    endtask

    // ***********************************************************************
    // Scenarios
    // ***********************************************************************
    task automatic t_reset_and_words();
        rflags(8'h00);
        t16_cpu_model_inst.br(`T16_ADDR_MASK, b);
        chk(b, 8'h00);
        t16_cpu_model_inst.br(4'hD, b);
        chk(b, 8'h00);
        w16(`T16_ADDR_COUNT_L, 16'h1234);
        r16(`T16_ADDR_COUNT_L, v);
        chk(v, 16'h1234);
        $display("test reset_and_words done");
    endtask

    task automatic t_match_overflow_irq();
        w16(`T16_ADDR_CMPA_L, 16'hFFF8);
        w16(`T16_ADDR_COUNT_L, 16'hFFF0);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h01);
        repeat (40) @(posedge mclk);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h00);
        rflags(8'h1C);
        chk(cmp_pins, 2'h3);
        t16_cpu_model_inst.bw(`T16_ADDR_MASK, 8'h10);
        chk(irq, 1'b0);
        t16_cpu_model_inst.gie_set(1'b1);
        @(posedge mclk);
        @(negedge mclk);
        chk(irq, 1'b1);
        t16_cpu_model_inst.bw(`T16_ADDR_FLAGS, 8'h10);
        rflags(8'h0C);
        chk(irq, 1'b0);
        t16_cpu_model_inst.ack('{capt: 1'b0, cmpa: 1'b0, cmpb: 1'b0, ovf: 1'b1});
        rflags(8'h08);
        $display("test match_overflow_irq done");
    endtask

    task automatic t_write_blocks_match();
        t16_cpu_model_inst.bw(`T16_ADDR_FLAGS, 8'h3C);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_A, 8'h80);
        rflags(8'h00);
        t16_cpu_model_inst.br(`T16_ADDR_CTRL_A, b);
        chk(b, 8'h00);
        w16(`T16_ADDR_CMPA_L, 16'h0005);
        w16(`T16_ADDR_COUNT_L, 16'h0005);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h01);
        repeat (6) @(posedge mclk);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h00);
        rflags(8'h00);
        chk(cmp_pins, 2'h2);
        $display("test write_blocks_match done");
    endtask

    task automatic t_capture();
        w16(`T16_ADDR_COUNT_L, 16'h0ABC);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h40);
        cap_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        r16(`T16_ADDR_CAPT_L, v);
        chk(v, 16'h0ABC);
        rflags(8'h20);
        $display("test capture done");
    endtask

    // Mode 12: capture word as top, pin edge must be ignored
    task automatic t_capture_top();
        t16_cpu_model_inst.bw(`T16_ADDR_FLAGS, 8'h3C);
        w16(`T16_ADDR_CAPT_L, 16'h0010);
        w16(`T16_ADDR_COUNT_L, 16'h0000);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h19);
        cap_pin <= 1'b0;
        repeat (20) @(posedge mclk);
        t16_cpu_model_inst.bw(`T16_ADDR_CTRL_B, 8'h00);
        rflags(8'h38);
        r16(`T16_ADDR_CAPT_L, v);
        chk(v, 16'h0010);
        r16(`T16_ADDR_COUNT_L, v);
        chk(v, 16'h0005);
        chk(cmp_pins, 2'h1);
        chk(irq, 1'b1);
        $display("test capture_top done");
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset_and_words();
        t_match_overflow_irq();
        t_write_blocks_match();
        t_capture();
        t_capture_top();
        finish_test();
    end
endmodule
